// ---- cfd_defines.svh ----
// Offsets, field positions, reset values and counts of the filter and dispatch block
`ifndef CFD_DEFINES_SVH
`define CFD_DEFINES_SVH
`define CFD_ADDR_CMD        16'h0b01
`define CFD_ADDR_BT_LOW     16'h0b06
`define CFD_ADDR_BT_HIGH    16'h0b07
`define CFD_ADDR_DT_TOP     16'h0b24
`define CFD_ADDR_DT_B2      16'h0b25
`define CFD_ADDR_DT_B1      16'h0b26
`define CFD_ADDR_DT_B0      16'h0b27
`define CFD_ADDR_FLT_FIRST  16'h0b28
`define CFD_ADDR_FLT_LAST   16'h0c27
`define CFD_ADDR_PIN_SEL    16'h0f52
`define CFD_CMD_TX_BIT      0
`define CFD_CMD_RELEASE_BIT 2
`define CFD_GUARD_KEY       3'h6
`define CFD_RST_BYTE        8'h00
`define CFD_RST_PIN_SEL     4'h0
`define CFD_STD_BITS        11
`define CFD_EXT_BITS        29
`define CFD_BITS_PER_COUNT  7'h64
`define CFD_DISP_UNIT_US    200
`define CFD_VEC_CTRL_A      8'h4b
`define CFD_VEC_CTRL_B      8'h53
`define CFD_VEC_BUS_OFF     8'h73
`endif

// ---- cfd_pkg.sv ----
// Types shared by the filter and dispatch block
package cfd_pkg;
   typedef logic [7:0] cfd_byte_t;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_WAIT = 2'b01,
      TX_SEND = 2'b10
   } cfd_tx_state_t;
endpackage : cfd_pkg

// ---- cfd_bit_clock.sv ----
// Quantum and bit-time tick generator from prescaler and segment lengths
`timescale 1ns/1ns
`default_nettype none
module cfd_bit_clock
   import cfd_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       restart,
   input  wire logic [5:0] prescaler,
   input  wire logic [3:0] seg_one,
   input  wire logic [2:0] seg_two,
   output logic            bit_tick
);
   logic [6:0] q_cnt;
   logic [4:0] bit_q;
   logic [6:0] q_last;
   logic [4:0] bit_last;
   logic       q_tick;

   // Quantum is 2 clocks times prescaler plus one
   assign q_last   = {prescaler, 1'b1};
   // Sync quantum plus both segments, each field plus one
   assign bit_last = 5'({1'b0, seg_one}) + 5'({2'b0, seg_two}) + 5'h02;
   assign q_tick   = (q_cnt == q_last);

   // Quantum divider; restart keeps phase aligned to the caller
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q_cnt <= 7'h00;
      end else if (restart || q_tick) begin
         q_cnt <= 7'h00;
      end else begin
         q_cnt <= q_cnt + 7'h01;
      end
   end

   // Quanta per bit and the bit tick itself
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_q    <= 5'h00;
         bit_tick <= 1'b0;
      end else begin
         bit_tick <= 1'b0;
         if (restart) begin
            bit_q <= 5'h00;
         end else if (q_tick) begin
            if (bit_q == bit_last) begin
               bit_q    <= 5'h00;
               bit_tick <= 1'b1;
            end else begin
               bit_q <= bit_q + 5'h01;
            end
         end
      end
   end

   chk_restart_quiet : assert property (@(posedge sys_clk) disable iff (!rst_n)
      restart |=> !bit_tick) else $error("bit tick right after restart");
endmodule : cfd_bit_clock
`default_nettype wire

// ---- cfd_filter_dispatch.sv ----
// Filter match flags, dispatch timer, acceptance filters, pins and host handshakes
//
// Contract
// - Flags address reads dispatch byte in Silent
// - Passing filter sets its match flag
// - 28-bit dispatch value, zero disables it
// - Guard key 6 unlocks lower dispatch bytes
// - Dispatch registers reset to zero
// - One count is 100 bit times
// - Pin-select bits 3 and 2 enable pin pairs
// - Timing registers writable only in Silent
// - Quantum is two clocks times prescaler+1
// - Bit is sync, seg1+1, seg2+1 quanta
// - 32 filters, code and mask, mask ignores
// - Codes and masks reset to zero
// - Eight bytes per filter, code/mask interleaved
// - Standard compares 11 bits, extended 29
// - Level request per controller, bus-off edge
// - Transmit request waits for idle bus
// - Accepted frame sets receive interrupt flag
// - Nonzero value retransmits every 100*A bits
// - Failed dispatch frame is not retried
`timescale 1ns/1ns
`default_nettype none
`include "cfd_defines.svh"
module cfd_filter_dispatch
   import cfd_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic [15:0] xfr_addr,
   input  wire logic [7:0]  xfr_wdata,
   input  wire logic        xfr_wr,
   input  wire logic        xfr_rd,
   output cfd_byte_t        xfr_rdata,
   input  wire logic        silent_mode,
   input  wire logic        rx_frame_valid,
   input  wire logic        rx_ext,
   input  wire logic [28:0] rx_id,
   input  wire logic        rx_rtr,
   input  wire logic        rx_int_en,
   input  wire logic [5:0]  int_src,
   input  wire logic        bus_off,
   input  wire logic        bus_off_clr,
   input  wire logic        bus_idle,
   input  wire logic        tx_done,
   input  wire logic        tx_error,
   input  wire logic        core_tx,
   input  wire logic [1:0]  pin_rx,
   output logic [1:0]       pin_tx,
   output logic [1:0]       pin_tx_oe_n,
   output logic [3:0]       pin_func,
   output logic             core_rx,
   output logic             bit_tick,
   output logic             rx_accept,
   output logic             rx_int_flag,
   output logic             rx_release,
   output logic             tx_start,
   output logic             tx_is_dispatch,
   output logic             ctrl_irq_n,
   output logic             bus_off_irq_n
);
   logic            rst_s1, rst_n;
   logic [31:0]     match_flags, match;
   cfd_byte_t       dt_top, dt_b2, dt_b1, dt_b0;
   logic [27:0]     disp_val, period_cnt;
   logic [6:0]      bit_div;
   logic            disp_wr_ok, silent_q, leave_silent, disp_fire;
   logic [5:0]      prescaler;
   logic [3:0]      seg_one;
   logic [2:0]      seg_two;
   logic [3:0]      pin_sel;
   logic [31:0]     acc_code [32];
   logic [31:0]     acc_mask [32];
   logic [7:0]      flt_off;
   logic            flt_hit, wr_flt, wr_cmd, tx_pend, bus_off_q;
   logic [2:0]      rx_sync;
   cfd_tx_state_t   tx_state;

   // Reset release through two flops
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   assign flt_off  = 8'(xfr_addr - `CFD_ADDR_FLT_FIRST);
   assign flt_hit  = (xfr_addr >= `CFD_ADDR_FLT_FIRST) && (xfr_addr <= `CFD_ADDR_FLT_LAST);
   assign wr_flt   = xfr_wr && flt_hit;
   assign wr_cmd   = xfr_wr && (xfr_addr == `CFD_ADDR_CMD);
   assign disp_val = {dt_top[3:0], dt_b2, dt_b1, dt_b0};
   assign leave_silent = silent_q && !silent_mode;
   // Any accepted write to the value counts as a rewrite
   assign disp_wr_ok = xfr_wr && silent_mode && ((xfr_addr == `CFD_ADDR_DT_TOP) ||
                       (((xfr_addr == `CFD_ADDR_DT_B2) || (xfr_addr == `CFD_ADDR_DT_B1) ||
                         (xfr_addr == `CFD_ADDR_DT_B0)) &&
                        ({dt_top[7], dt_top[5], dt_top[4]} == `CFD_GUARD_KEY)));

   // Dispatch value and guard bits; outside Silent these addresses are flags
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dt_top <= `CFD_RST_BYTE;
         dt_b2  <= `CFD_RST_BYTE;
         dt_b1  <= `CFD_RST_BYTE;
         dt_b0  <= `CFD_RST_BYTE;
      end else if (disp_wr_ok) begin
         case (xfr_addr)
            `CFD_ADDR_DT_TOP: dt_top <= xfr_wdata;
            `CFD_ADDR_DT_B2:  dt_b2  <= xfr_wdata;
            `CFD_ADDR_DT_B1:  dt_b1  <= xfr_wdata;
            `CFD_ADDR_DT_B0:  dt_b0  <= xfr_wdata;
            default:          dt_b0  <= dt_b0;
         endcase
      end
   end

   // Bit timing, only while Silent; pin select any time
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prescaler <= 6'h00;
         seg_one   <= 4'h0;
         seg_two   <= 3'h0;
         pin_sel   <= `CFD_RST_PIN_SEL;
      end else if (xfr_wr) begin
         if (silent_mode && xfr_addr == `CFD_ADDR_BT_LOW) begin
            prescaler <= xfr_wdata[5:0];
         end
         if (silent_mode && xfr_addr == `CFD_ADDR_BT_HIGH) begin
            seg_one <= xfr_wdata[3:0];
            seg_two <= xfr_wdata[6:4];
         end
         if (xfr_addr == `CFD_ADDR_PIN_SEL) begin
            pin_sel <= xfr_wdata[3:0];
         end
      end
   end

   // Filter storage: even byte is code, odd is mask, top byte first
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 32; i++) begin
            acc_code[i] <= 32'h0000_0000;
            acc_mask[i] <= 32'h0000_0000;
         end
      end else if (wr_flt) begin
         if (flt_off[0]) begin
            acc_mask[flt_off[7:3]][8*(3-flt_off[2:1]) +: 8] <= xfr_wdata;
         end else begin
            acc_code[flt_off[7:3]][8*(3-flt_off[2:1]) +: 8] <= xfr_wdata;
         end
      end
   end

   // One comparator per filter; a set mask bit never blocks a match
   for (genvar g = 0; g < 32; g++) begin : g_flt
      logic [31:0] diff;
      assign diff = (acc_code[g] ^ (rx_ext ? {3'h0, rx_id[27:0], rx_rtr}
                                           : {21'h0, rx_id[28:18]})) & ~acc_mask[g];
      assign match[g] = rx_ext ? (diff[`CFD_EXT_BITS-1:0] == 29'h0)
                               : (diff[`CFD_STD_BITS-1:0] == 11'h0);
   end

   // Match flags: new hits set, release clears, set wins over clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         match_flags <= 32'h0000_0000;
      end else begin
         match_flags <= (match_flags & {32{!rx_release}}) |
                        (rx_frame_valid ? match : 32'h0000_0000);
      end
   end

   // Receive events and buffer release command
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_accept   <= 1'b0;
         rx_int_flag <= 1'b0;
         rx_release  <= 1'b0;
      end else begin
         rx_accept  <= rx_frame_valid && (|match);
         rx_release <= wr_cmd && xfr_wdata[`CFD_CMD_RELEASE_BIT];
         if (rx_frame_valid && (|match) && rx_int_en) begin
            rx_int_flag <= 1'b1;
         end else if (rx_release) begin
            rx_int_flag <= 1'b0;
         end
      end
   end

   // Register read port, answered one clock after the strobe
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         xfr_rdata <= `CFD_RST_BYTE;
      end else if (xfr_rd) begin
         if (flt_hit) begin
            xfr_rdata <= flt_off[0] ? acc_mask[flt_off[7:3]][8*(3-flt_off[2:1]) +: 8]
                                    : acc_code[flt_off[7:3]][8*(3-flt_off[2:1]) +: 8];
         end else begin
            case (xfr_addr)
               `CFD_ADDR_DT_TOP:  xfr_rdata <= silent_mode ? dt_top : match_flags[31:24];
               `CFD_ADDR_DT_B2:   xfr_rdata <= silent_mode ? dt_b2 : match_flags[23:16];
               `CFD_ADDR_DT_B1:   xfr_rdata <= silent_mode ? dt_b1 : match_flags[15:8];
               `CFD_ADDR_DT_B0:   xfr_rdata <= silent_mode ? dt_b0 : match_flags[7:0];
               `CFD_ADDR_BT_LOW:  xfr_rdata <= {2'h0, prescaler};
               `CFD_ADDR_BT_HIGH: xfr_rdata <= {1'b0, seg_two, seg_one};
               `CFD_ADDR_PIN_SEL: xfr_rdata <= {4'h0, pin_sel};
               default:           xfr_rdata <= `CFD_RST_BYTE;
            endcase
         end
      end
   end

   // Bit clock is held in Silent so the period restarts on leaving it
   cfd_bit_clock u_bit_clock (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .restart   (silent_mode),
      .prescaler (prescaler),
      .seg_one   (seg_one),
      .seg_two   (seg_two),
      .bit_tick  (bit_tick)
   );

   // Dispatch period: 100 bit times per count, A counts per frame
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         silent_q   <= 1'b0;
         bit_div    <= 7'h00;
         period_cnt <= 28'h000_0000;
         disp_fire  <= 1'b0;
      end else begin
         silent_q  <= silent_mode;
         disp_fire <= 1'b0;
         if (disp_wr_ok || leave_silent || disp_val == 28'h000_0000) begin
            bit_div    <= 7'h00;
            period_cnt <= 28'h000_0000;
         end else if (bit_tick) begin
            if (bit_div == `CFD_BITS_PER_COUNT - 7'h01) begin
               bit_div <= 7'h00;
               if (period_cnt == disp_val - 28'h000_0001) begin
                  period_cnt <= 28'h000_0000;
                  disp_fire  <= 1'b1;
               end else begin
                  period_cnt <= period_cnt + 28'h000_0001;
               end
            end else begin
               bit_div <= bit_div + 7'h01;
            end
         end
      end
   end

   // Transmit sequencing: request, wait for idle bus, hand frame over
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state       <= TX_IDLE;
         tx_pend        <= 1'b0;
         tx_is_dispatch <= 1'b0;
         tx_start       <= 1'b0;
      end else begin
         tx_start <= 1'b0;
         case (tx_state)
            TX_IDLE: if (tx_pend && !silent_mode) begin
               tx_state <= TX_WAIT;
               tx_pend  <= 1'b0;
            end
            TX_WAIT: if (bus_idle) begin
               tx_state <= TX_SEND;
               tx_start <= 1'b1;
            end
            TX_SEND: if (tx_done) begin
               tx_state       <= TX_IDLE;
               tx_is_dispatch <= 1'b0;
            end else if (tx_error) begin
               // Dispatch frames are dropped; host frames try again
               tx_state       <= tx_is_dispatch ? TX_IDLE : TX_WAIT;
               tx_is_dispatch <= 1'b0;
            end
            default: tx_state <= TX_IDLE;
         endcase
         // New requests come last so a set in the same cycle as a take is never lost
         if (wr_cmd && xfr_wdata[`CFD_CMD_TX_BIT]) begin
            tx_pend <= 1'b1;
         end else if (disp_fire && tx_state == TX_IDLE) begin
            tx_pend        <= 1'b1;
            tx_is_dispatch <= 1'b1;
         end
      end
   end

   // Interrupt requests: level request follows sources, bus-off latches low
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_irq_n    <= 1'b1;
         bus_off_q     <= 1'b0;
         bus_off_irq_n <= 1'b1;
      end else begin
         ctrl_irq_n <= !(rx_int_flag || (|int_src));
         bus_off_q  <= bus_off;
         if (bus_off && !bus_off_q) begin
            bus_off_irq_n <= 1'b0;
         end else if (bus_off_clr) begin
            bus_off_irq_n <= 1'b1;
         end
      end
   end

   // Pin groups; receive pins come from outside, so three flops and agreement
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sync     <= 3'h7;
         core_rx     <= 1'b1;
         pin_tx      <= 2'h3;
         pin_tx_oe_n <= 2'h3;
         pin_func    <= 4'h0;
      end else begin
         rx_sync     <= {rx_sync[1:0], pin_sel[3] ? pin_rx[1] : (pin_sel[2] ? pin_rx[0] : 1'b1)};
         if (rx_sync[1] == rx_sync[2]) begin
            core_rx <= rx_sync[2];
         end
         pin_tx      <= {2{core_tx}};
         pin_tx_oe_n <= ~pin_sel[3:2];
         pin_func    <= pin_sel;
      end
   end

   sequence s_ready_to_send;
      tx_state == TX_WAIT && bus_idle;
   endsequence

   chk_flags_readonly : assert property (xfr_wr && !silent_mode && xfr_addr == `CFD_ADDR_DT_B0
      |=> $stable(dt_b0)) else $error("flags address wrote dispatch byte");
   chk_flag_set : assert property (rx_frame_valid |=> (match_flags & $past(match)) == $past(match))
      else $error("match flag not set");
   chk_disp_zero : assert property (disp_val == 28'h000_0000 |=> !disp_fire)
      else $error("dispatch with zero value");
   chk_guard_lock : assert property (xfr_wr && xfr_addr == `CFD_ADDR_DT_B2 &&
      {dt_top[7], dt_top[5], dt_top[4]} != `CFD_GUARD_KEY |=> $stable(dt_b2))
      else $error("guarded byte written while locked");
   chk_guard_open : assert property (xfr_wr && silent_mode && xfr_addr == `CFD_ADDR_DT_B1 &&
      {dt_top[7], dt_top[5], dt_top[4]} == `CFD_GUARD_KEY |=> dt_b1 == $past(xfr_wdata))
      else $error("unlocked write lost");
   chk_timing_lock : assert property (xfr_wr && !silent_mode && xfr_addr == `CFD_ADDR_BT_LOW
      |=> $stable(prescaler)) else $error("timing written outside Silent");
   chk_tx_idle_wait : assert property (s_ready_to_send |=> tx_start && tx_state == TX_SEND)
      else $error("frame not started on idle bus");
   chk_rx_int : assert property (rx_frame_valid && (|match) && rx_int_en |=> rx_int_flag ##1 1'b1)
      else $error("receive flag missed");
   chk_disp_noretry : assert property (tx_state == TX_SEND && !tx_done && tx_error && tx_is_dispatch
      |=> tx_state == TX_IDLE) else $error("dispatch frame retried");
   chk_disp_restart : assert property (leave_silent |=> period_cnt == 28'h000_0000 && bit_div == 7'h00)
      else $error("period not restarted");
endmodule : cfd_filter_dispatch
`default_nettype wire

// ---- cfd_node_model.sv ----
// Behavioural far-side bus node: idle detection, frame completion and receive pins
`timescale 1ns/1ns
`default_nettype none
module cfd_node_model (
   input  wire logic       sys_clk,
   input  wire logic       tx_start,
   input  wire logic       hold_busy,
   input  wire logic       fail_next,
   input  wire logic       drive_dom,
   output logic            bus_idle,
   output logic            tx_done,
   output logic            tx_error,
   output logic [1:0]      pin_rx
);
   int   sending  = 0;
   logic done_q   = 1'b0;
   logic err_q    = 1'b0;
   // A frame occupies the bus for 20 clocks, then ends well or with an error
   always @(posedge sys_clk) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
      if (tx_start) begin
         sending <= 20;
      end else if (sending == 1) begin
         done_q <= !fail_next;
         err_q <= fail_next;
         sending <= 0;
      end else if (sending > 1) begin
         sending <= sending - 1;
      end
   end
   assign tx_done  = done_q;
   assign tx_error = err_q;
   // Idle only when no node talks; the bench can keep the bus busy
   assign bus_idle = !hold_busy && sending == 0;
   // Released lines are recessive, pulled high; only pin_rx[1] goes dominant, pin_rx[0] never does
   assign pin_rx = drive_dom ? 2'b01 : 2'b11;
endmodule : cfd_node_model
`default_nettype wire

// ---- cfd_filter_dispatch_test.sv ----
// Self-checking bench for the filter and dispatch block
`timescale 1ns/1ns
`default_nettype none
module cfd_filter_dispatch_test
   import cfd_pkg::*;
;
   typedef struct packed {logic wr; logic sil; logic [15:0] a; cfd_byte_t d; cfd_byte_t e;} cfd_row_t;
   typedef struct packed {logic ext; logic [28:0] id; logic rtr; logic acc; cfd_byte_t fl;} cfd_frame_t;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [15:0] xfr_addr;
   cfd_byte_t   xfr_wdata, xfr_rdata, v;
   logic        xfr_wr, xfr_rd, silent_mode, rx_frame_valid, rx_ext, rx_rtr, rx_int_en;
   logic [28:0] rx_id;
   logic [5:0]  int_src;
   logic        bus_off, bus_off_clr, bus_idle, tx_done, tx_error, core_tx, core_rx, bit_tick;
   logic [1:0]  pin_rx, pin_tx, pin_tx_oe_n;
   logic [3:0]  pin_func;
   logic        rx_accept, rx_int_flag, rx_release, tx_start, tx_is_dispatch, ctrl_irq_n, bus_off_irq_n;
   logic        hold_busy, fail_next, drive_dom;
   int          err_total = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          n;
   cfd_row_t    rows [14] = '{
      '{1'b1, 1'b1, 16'h0b24, 8'hb0, 8'hb0}, '{1'b1, 1'b1, 16'h0b25, 8'h12, 8'h00},
      '{1'b1, 1'b1, 16'h0b24, 8'ha0, 8'ha0}, '{1'b1, 1'b1, 16'h0b25, 8'h12, 8'h12},
      '{1'b1, 1'b1, 16'h0b25, 8'h00, 8'h00}, '{1'b1, 1'b1, 16'h0b26, 8'h34, 8'h34},
      '{1'b1, 1'b1, 16'h0b26, 8'h00, 8'h00}, '{1'b1, 1'b0, 16'h0b24, 8'hff, 8'h00},
      '{1'b0, 1'b1, 16'h0b24, 8'h00, 8'ha0}, '{1'b1, 1'b0, 16'h0b06, 8'h3f, 8'h00},
      '{1'b1, 1'b1, 16'h0b28, 8'h5a, 8'h5a}, '{1'b1, 1'b0, 16'h0a00, 8'h55, 8'h00},
      '{1'b1, 1'b1, 16'h0f52, 8'h0a, 8'h0a}, '{1'b1, 1'b0, 16'h0b27, 8'h55, 8'h00}};
   cfd_frame_t  frames [4] = '{
      '{1'b0, 29'h048c0000, 1'b0, 1'b1, 8'h01}, '{1'b0, 29'h04900000, 1'b0, 1'b0, 8'h00},
      '{1'b1, 29'h00000001, 1'b0, 1'b1, 8'h02}, '{1'b1, 29'h00000001, 1'b1, 1'b0, 8'h00}};
   logic [15:0] flt_a [7] = '{16'h0b29, 16'h0b2b, 16'h0b2d, 16'h0b2c, 16'h0b2e, 16'h0b31, 16'h0b36};
   cfd_byte_t   flt_d [7] = '{8'hff, 8'hff, 8'hf8, 8'h01, 8'h23, 8'he0, 8'h02};

   cfd_filter_dispatch i_dut (.sys_clk(sys_clk), .nrst(nrst), .xfr_addr(xfr_addr), .xfr_wdata(xfr_wdata),
      .xfr_wr(xfr_wr), .xfr_rd(xfr_rd), .xfr_rdata(xfr_rdata), .silent_mode(silent_mode),
      .rx_frame_valid(rx_frame_valid), .rx_ext(rx_ext), .rx_id(rx_id), .rx_rtr(rx_rtr),
      .rx_int_en(rx_int_en), .int_src(int_src), .bus_off(bus_off), .bus_off_clr(bus_off_clr),
      .bus_idle(bus_idle), .tx_done(tx_done), .tx_error(tx_error), .core_tx(core_tx), .pin_rx(pin_rx),
      .pin_tx(pin_tx), .pin_tx_oe_n(pin_tx_oe_n), .pin_func(pin_func), .core_rx(core_rx),
      .bit_tick(bit_tick), .rx_accept(rx_accept), .rx_int_flag(rx_int_flag), .rx_release(rx_release),
      .tx_start(tx_start), .tx_is_dispatch(tx_is_dispatch), .ctrl_irq_n(ctrl_irq_n),
      .bus_off_irq_n(bus_off_irq_n));
   cfd_node_model i_node (.sys_clk(sys_clk), .tx_start(tx_start), .hold_busy(hold_busy),
      .fail_next(fail_next), .drive_dom(drive_dom), .bus_idle(bus_idle), .tx_done(tx_done),
      .tx_error(tx_error), .pin_rx(pin_rx));

   // 50 MHz clock and a cycle ceiling well above the planned run
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 12000) begin
         err_total++;
         close_out();
      end
   end

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_val

   task automatic chk_num(input string nm, input int e, input int g);
      tests_run++;
      if (g != e) begin
         err_total++;
         $display("BAD %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_num

   // Inputs always move 1 ns after the rising edge
   task automatic step(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : step

   task automatic wr(input logic [15:0] a, input cfd_byte_t d);
      xfr_addr = a;
      xfr_wdata = d;
      xfr_wr = 1'b1;
      step(1);
      xfr_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, output cfd_byte_t q);
      xfr_addr = a;
      xfr_rd = 1'b1;
      step(1);
      xfr_rd = 1'b0;
      q = xfr_rdata;
      // A spare cycle so a following read never lowers and raises the strobe at once
      step(1);
   endtask : rd

   // Counts cycles until a transfer starts; lim+1 means none came
   task automatic wait_start(input int lim, output int c);
      c = 0;
      while (tx_start !== 1'b1 && c <= lim) begin
         step(1);
         c++;
      end
   endtask : wait_start

   task automatic tick_gap(output int c);
      c = 0;
      step(1);
      while (bit_tick !== 1'b1 && c < 100) begin
         step(1);
         c++;
      end
   endtask : tick_gap

   initial begin
      {xfr_addr, xfr_wdata, xfr_wr, xfr_rd, silent_mode, rx_frame_valid, rx_ext, rx_id, rx_rtr} = '0;
      {rx_int_en, int_src, bus_off, bus_off_clr, hold_busy, fail_next, drive_dom} = '0;
      core_tx = 1'b1;
      step(4);
      nrst = 1'b1;
      step(3);
      // Register table: writes, guard key and shared flag addresses
      foreach (rows[i]) begin
         silent_mode = rows[i].sil;
         if (rows[i].wr) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, v);
         chk_val("register", rows[i].e, v);
      end
      // Pin group: one valid group per controller
      wr(16'h0f52, 8'h08);
      step(1);
      chk_val("pin_func", 8'h08, pin_func);
      chk_val("pin_tx_oe_n", 8'h01, pin_tx_oe_n);
      core_tx = 1'b0;
      drive_dom = 1'b1;
      step(5);
      chk_val("core_rx", 8'h00, core_rx);
      chk_val("pin_tx", 8'h00, pin_tx[1]);
      core_tx = 1'b1;
      drive_dom = 1'b0;
      // Filters 0 and 1, unused mask bits set to don't care
      silent_mode = 1'b1;
      foreach (flt_a[i]) begin
         wr(flt_a[i], flt_d[i]);
         step(1);
      end
      silent_mode = 1'b0;
      rx_int_en = 1'b1;
      foreach (frames[i]) begin
         {rx_ext, rx_id, rx_rtr} = {frames[i].ext, frames[i].id, frames[i].rtr};
         rx_frame_valid = 1'b1;
         step(1);
         rx_frame_valid = 1'b0;
         chk_val("rx_accept", frames[i].acc, rx_accept);
         chk_val("rx_int_flag", frames[i].acc, rx_int_flag);
         step(1);
         chk_val("ctrl_irq_n", !frames[i].acc, ctrl_irq_n);
         rd(16'h0b27, v);
         chk_val("match flags", frames[i].fl, v);
         wr(16'h0b01, 8'h04);
         chk_val("rx_release", 8'h01, rx_release);
         step(1);
      end
      // Host transmit waits for an idle bus
      hold_busy = 1'b1;
      wr(16'h0b01, 8'h01);
      wait_start(10, n);
      chk_num("start while busy", 11, n);
      hold_busy = 1'b0;
      wait_start(5, n);
      chk_val("start after idle", 8'h01, n <= 2);
      chk_val("host frame kind", 8'h00, tx_is_dispatch);
      step(25);
      // Bit time for two prescaler and segment settings, 6 clocks left last
      for (int k = 1; k >= 0; k--) begin
         silent_mode = 1'b1;
         wr(16'h0b06, k ? 8'h01 : 8'h00);
         step(1);
         wr(16'h0b07, k ? 8'h12 : 8'h00);
         silent_mode = 1'b0;
         tick_gap(n);
         tick_gap(n);
         chk_num("bit period", k ? 24 : 6, n + 1);
      end
      // Dispatch value 1: 100 bit times, failed frame not retried
      silent_mode = 1'b1;
      wr(16'h0b27, 8'h01);
      silent_mode = 1'b0;
      wait_start(700, n);
      chk_val("dispatch kind", 8'h01, tx_is_dispatch);
      fail_next = 1'b1;
      step(1);
      wait_start(700, n);
      chk_num("dispatch gap", 600, n + 1);
      fail_next = 1'b0;
      step(25);
      chk_val("dispatch dropped", 8'h00, tx_is_dispatch);
      silent_mode = 1'b1;
      wr(16'h0b27, 8'h00);
      silent_mode = 1'b0;
      wait_start(700, n);
      chk_num("dispatch off", 701, n);
      // Controller level request and shared bus-off edge request
      int_src = 6'h04;
      step(2);
      chk_val("ctrl_irq_n low", 8'h00, ctrl_irq_n);
      int_src = 6'h00;
      bus_off = 1'b1;
      step(2);
      chk_val("ctrl_irq_n high", 8'h01, ctrl_irq_n);
      chk_val("bus_off_irq_n fell", 8'h00, bus_off_irq_n);
      bus_off = 1'b0;
      step(3);
      chk_val("bus_off_irq_n held", 8'h00, bus_off_irq_n);
      bus_off_clr = 1'b1;
      step(1);
      bus_off_clr = 1'b0;
      step(1);
      chk_val("bus_off_irq_n clear", 8'h01, bus_off_irq_n);
      // Reset in mid-run clears dispatch, filters and pin select
      nrst = 1'b0;
      step(2);
      chk_val("pin_func reset", 8'h00, pin_func);
      nrst = 1'b1;
      step(3);
      silent_mode = 1'b1;
      rd(16'h0b24, v);
      chk_val("dispatch top reset", 8'h00, v);
      rd(16'h0b25, v);
      chk_val("dispatch byte reset", 8'h00, v);
      rd(16'h0b36, v);
      chk_val("filter code reset", 8'h00, v);
      rd(16'h0b31, v);
      chk_val("filter mask reset", 8'h00, v);
      close_out();
   end
endmodule : cfd_filter_dispatch_test
`default_nettype wire
